// ### logic/hub_power_cfg.svh
// Constants for the hub power configuration register bank.
// Assumes inclusion by bare name from files under logic/.
`ifndef HUB_POWER_CFG_SVH
`define HUB_POWER_CFG_SVH
`define OFS_SELF_MAX_POWER 8'h0c
`define OFS_BUS_MAX_POWER 8'h0d
`define OFS_CTRL_CUR_SELF 8'h0e
`define OFS_CTRL_CUR_BUS 8'h0f
`define OFS_POWER_GOOD_DELAY 8'h10
`define REG_RESET_VALUE 8'h00
`define UNMAPPED_READ_VALUE 8'h00
`define CTRL_CUR_DEFAULT 8'h32
`define CURRENT_STEP_MA 16'h0002
`define POWER_ON_STEP_MS 16'h0002
`define SELF_POWER_LIMIT 8'h32
`endif

// ### logic/hub_power_pkg.sv
// Types shared by the hub power configuration register bank.
// Assumes no other packages.
package hub_power_pkg;
   typedef struct packed {
      logic [7:0] self_powered_max_power;
      logic [7:0] bus_powered_max_power;
      logic [7:0] controller_current_self_powered;
      logic [7:0] controller_current_bus_powered;
      logic [7:0] port_power_good_delay;
   } power_regs_s;
   typedef struct packed {
      logic [7:0] max_power;
      logic [7:0] controller_current;
      logic [15:0] max_power_ma;
      logic [15:0] controller_current_ma;
      logic [15:0] power_good_delay_ms;
   } descriptor_power_s;
   typedef enum logic [0:0] {
      BUS_POWERED = 1'b0,
      SELF_POWERED = 1'b1
   } power_mode_e;
endpackage : hub_power_pkg

// ### logic/power_unit_scale.sv
// Scales an 8-bit register count into milliamps or milliseconds.
// Assumes same-clock, combinational use by the register bank.
`timescale 1ns/1ns
`include "hub_power_cfg.svh"
module power_unit_scale (
   input wire logic [7:0] count,
   input wire logic [15:0] step,
   output logic [15:0] scaled
);
   always_comb begin
      scaled = 16'({8'h00, count} * step);
   end
endmodule : power_unit_scale

// ### logic/hub_power_config_registers.sv
// Power budget configuration register bank of a two-port hub controller.
// Assumes a byte-wide configuration port driven by the loader on clk.
`timescale 1ns/1ns
`include "hub_power_cfg.svh"
module hub_power_config_registers (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cfg_write,
   input wire logic cfg_read,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_error,
   input wire logic load_defaults,
   input wire logic power_source_select,
   input wire logic compound_device,
   output hub_power_pkg::power_regs_s regs,
   output hub_power_pkg::descriptor_power_s descriptor,
   output logic peripheral_power_relevant,
   output logic self_power_limit_exceeded
);
   hub_power_pkg::power_regs_s next_regs;
   hub_power_pkg::descriptor_power_s next_descriptor;
   logic [7:0] next_rdata;
   logic [15:0] max_power_ma;
   logic [15:0] controller_current_ma;
   logic [15:0] delay_ms;
   hub_power_pkg::power_mode_e mode;

   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr >= `OFS_SELF_MAX_POWER) && (addr <= `OFS_POWER_GOOD_DELAY);
   endfunction : is_mapped

   function automatic logic [7:0] read_reg(input hub_power_pkg::power_regs_s r,
                                           input logic [7:0] addr);
      unique case (addr)
         `OFS_SELF_MAX_POWER: read_reg = r.self_powered_max_power;
         `OFS_BUS_MAX_POWER: read_reg = r.bus_powered_max_power;
         `OFS_CTRL_CUR_SELF: read_reg = r.controller_current_self_powered;
         `OFS_CTRL_CUR_BUS: read_reg = r.controller_current_bus_powered;
         `OFS_POWER_GOOD_DELAY: read_reg = r.port_power_good_delay;
         default: read_reg = `UNMAPPED_READ_VALUE;
      endcase
   endfunction : read_reg

   assign mode = hub_power_pkg::power_mode_e'(power_source_select);

   // Register updates; a defaults load wins over a same-cycle write.
   always_comb begin
      next_regs = regs;
      if (load_defaults) begin
         // Internal defaults give the controller currents 50, not the zero of reset.
         next_regs.controller_current_self_powered = `CTRL_CUR_DEFAULT;
         next_regs.controller_current_bus_powered = `CTRL_CUR_DEFAULT;
      end else if (cfg_write && is_mapped(cfg_addr)) begin
         unique case (cfg_addr)
            `OFS_SELF_MAX_POWER: next_regs.self_powered_max_power = cfg_wdata;
            `OFS_BUS_MAX_POWER: next_regs.bus_powered_max_power = cfg_wdata;
            `OFS_CTRL_CUR_SELF: next_regs.controller_current_self_powered = cfg_wdata;
            `OFS_CTRL_CUR_BUS: next_regs.controller_current_bus_powered = cfg_wdata;
            `OFS_POWER_GOOD_DELAY: next_regs.port_power_good_delay = cfg_wdata;
            default: next_regs = regs;
         endcase
      end
   end

   always_comb begin
      next_rdata = cfg_rdata;
      if (cfg_read) begin
         next_rdata = read_reg(regs, cfg_addr);
      end
   end

   // Pick the fields for the present power mode.
   always_comb begin
      next_descriptor = '0;
      if (mode == hub_power_pkg::SELF_POWERED) begin
         next_descriptor.max_power = regs.self_powered_max_power;
         next_descriptor.controller_current = regs.controller_current_self_powered;
      end else begin
         next_descriptor.max_power = regs.bus_powered_max_power;
         next_descriptor.controller_current = regs.controller_current_bus_powered;
      end
      next_descriptor.max_power_ma = max_power_ma;
      next_descriptor.controller_current_ma = controller_current_ma;
      next_descriptor.power_good_delay_ms = delay_ms;
   end

   power_unit_scale scale_max (
      .count(mode == hub_power_pkg::SELF_POWERED ? regs.self_powered_max_power
                                                 : regs.bus_powered_max_power),
      .step(`CURRENT_STEP_MA),
      .scaled(max_power_ma)
   );
   power_unit_scale scale_cur (
      .count(mode == hub_power_pkg::SELF_POWERED ? regs.controller_current_self_powered
                                                 : regs.controller_current_bus_powered),
      .step(`CURRENT_STEP_MA),
      .scaled(controller_current_ma)
   );
   power_unit_scale scale_delay (
      .count(regs.port_power_good_delay),
      .step(`POWER_ON_STEP_MS),
      .scaled(delay_ms)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regs <= '0;
         cfg_rdata <= `UNMAPPED_READ_VALUE;
         descriptor <= '0;
      end else begin
         regs <= next_regs;
         cfg_rdata <= next_rdata;
         descriptor <= next_descriptor;
      end
   end

   // Writes never fail, mapped or not.
   assign cfg_error = 1'b0;
   // Embedded peripheral consumption counts only in a compound device.
   assign peripheral_power_relevant = compound_device;
   // Flags a loader that broke the self-powered limit; the values are kept as written.
   assign self_power_limit_exceeded =
      (regs.self_powered_max_power > `SELF_POWER_LIMIT) ||
      (regs.controller_current_self_powered > `SELF_POWER_LIMIT);

   // Port and descriptor checks; the descriptor trails regs and mode by one edge.
   a_unmapped_write_kept: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && !is_mapped(cfg_addr)) |=> regs == $past(regs))
      else $error("unmapped write changed a register");
   a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_read && !is_mapped(cfg_addr)) |=> cfg_rdata == `UNMAPPED_READ_VALUE)
      else $error("unmapped read not zero");
   a_self_max_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && cfg_addr == `OFS_SELF_MAX_POWER) |=>
      regs.self_powered_max_power == $past(cfg_wdata))
      else $error("self max power write lost");
   a_bus_max_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && cfg_addr == `OFS_BUS_MAX_POWER) |=>
      regs.bus_powered_max_power == $past(cfg_wdata) &&
      regs.self_powered_max_power == $past(regs.self_powered_max_power))
      else $error("bus max power write wrong");
   a_ctrl_self_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && cfg_addr == `OFS_CTRL_CUR_SELF) |=>
      regs.controller_current_self_powered == $past(cfg_wdata))
      else $error("self controller current write lost");
   a_ctrl_bus_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && cfg_addr == `OFS_CTRL_CUR_BUS) |=>
      regs.controller_current_bus_powered == $past(cfg_wdata))
      else $error("bus controller current write lost");
   a_delay_write: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_write && !load_defaults && cfg_addr == `OFS_POWER_GOOD_DELAY) |=>
      regs.port_power_good_delay == $past(cfg_wdata))
      else $error("power good delay write lost");
   a_defaults_fifty: assert property (@(posedge clk) disable iff (!arst_n)
      load_defaults |=> regs.controller_current_self_powered == `CTRL_CUR_DEFAULT &&
      regs.controller_current_bus_powered == `CTRL_CUR_DEFAULT)
      else $error("controller current default not 50");
   a_defaults_keep_others: assert property (@(posedge clk) disable iff (!arst_n)
      load_defaults |=> regs.self_powered_max_power == $past(regs.self_powered_max_power) &&
      regs.bus_powered_max_power == $past(regs.bus_powered_max_power) &&
      regs.port_power_good_delay == $past(regs.port_power_good_delay))
      else $error("defaults load touched other registers");
   a_delay_scaled: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> descriptor.power_good_delay_ms ==
      16'($past(regs.port_power_good_delay)) * `POWER_ON_STEP_MS)
      else $error("power good delay not in 2 ms steps");
   a_mode_select: assert property (@(posedge clk) disable iff (!arst_n)
      power_source_select |=> descriptor.max_power == $past(regs.self_powered_max_power) &&
      descriptor.max_power_ma == 16'($past(regs.self_powered_max_power)) * `CURRENT_STEP_MA)
      else $error("self-powered fields not selected");
   a_self_ctrl_current: assert property (@(posedge clk) disable iff (!arst_n)
      power_source_select |=>
      descriptor.controller_current == $past(regs.controller_current_self_powered) &&
      descriptor.controller_current_ma ==
      16'($past(regs.controller_current_self_powered)) * `CURRENT_STEP_MA)
      else $error("self-powered controller current not selected");
   a_bus_mode_select: assert property (@(posedge clk) disable iff (!arst_n)
      !power_source_select |=> descriptor.max_power == $past(regs.bus_powered_max_power) &&
      descriptor.max_power_ma == 16'($past(regs.bus_powered_max_power)) * `CURRENT_STEP_MA)
      else $error("bus-powered fields not selected");
   a_bus_ctrl_current: assert property (@(posedge clk) disable iff (!arst_n)
      !power_source_select |=>
      descriptor.controller_current == $past(regs.controller_current_bus_powered) &&
      descriptor.controller_current_ma ==
      16'($past(regs.controller_current_bus_powered)) * `CURRENT_STEP_MA)
      else $error("bus-powered controller current not selected");
   a_readback_same: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_read && cfg_addr == `OFS_POWER_GOOD_DELAY && !cfg_write && !load_defaults) |=>
      cfg_rdata == regs.port_power_good_delay)
      else $error("readback differs from register");
   a_readback_self_max: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_read && cfg_addr == `OFS_SELF_MAX_POWER && !cfg_write && !load_defaults) |=>
      cfg_rdata == regs.self_powered_max_power)
      else $error("self max power readback differs from register");
   a_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !cfg_read |=> $stable(cfg_rdata))
      else $error("read data changed without a read");
   a_limit_ctrl_self: assert property (@(posedge clk) disable iff (!arst_n)
      (regs.controller_current_self_powered > `SELF_POWER_LIMIT) |-> self_power_limit_exceeded)
      else $error("controller current over limit not flagged");
   a_reset_zero: assert property (@(posedge clk)
      $rose(arst_n) |-> regs == '0)
      else $error("registers not zero after reset");
   a_reset_outputs: assert property (@(posedge clk)
      $rose(arst_n) |-> cfg_rdata == `UNMAPPED_READ_VALUE && descriptor == '0)
      else $error("read data or descriptor not cleared by reset");
endmodule : hub_power_config_registers

// ### test/cfg_loader_model.sv
// Model of the configuration source that loads the hub power register bank.
// Assumes clk from the bench and a read port that answers one edge after the request.
`timescale 1ns/1ns
module cfg_loader_model (
   input wire logic clk,
   input wire logic [7:0] cfg_rdata,
   output logic cfg_write,
   output logic cfg_read,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata
);
   initial begin
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      cfg_addr = 8'h5a;
      cfg_wdata = 8'ha5;
   end
   // Released address and data lines show the inverse of the last value, so stale data is never trusted.
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk);
      #10;
      cfg_write = wr;
      cfg_read = ~wr;
      cfg_addr = a;
      cfg_wdata = d;
      @(posedge clk);
      #10;
      q = cfg_rdata;
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~d;
   endtask : access
endmodule : cfg_loader_model

// ### test/hub_power_config_registers_tb_top.sv
// Self-checking bench for the hub power configuration register bank.
// Assumes the bank and the loader model compiled before it.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module hub_power_config_registers_tb_top;
   logic clk, arst_n, load_defaults, power_source_select, compound_device;
   logic cfg_write, cfg_read, cfg_error, peripheral_power_relevant, self_power_limit_exceeded;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rd;
   hub_power_pkg::power_regs_s regs;
   hub_power_pkg::descriptor_power_s descriptor;
   int n_errors = 0;
   int checks_done = 0;
   hub_power_config_registers dut_u (.clk(clk), .arst_n(arst_n), .cfg_write(cfg_write),
      .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_error(cfg_error), .load_defaults(load_defaults),
      .power_source_select(power_source_select), .compound_device(compound_device),
      .regs(regs), .descriptor(descriptor), .peripheral_power_relevant(peripheral_power_relevant),
      .self_power_limit_exceeded(self_power_limit_exceeded));
   cfg_loader_model loader_u (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_write(cfg_write),
      .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      loader_u.access(1'b1, a, d, rd);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      loader_u.access(1'b0, a, 8'h00, rd);
      `CHK(rd, e)
   endtask : rd_chk
   task automatic check_reset;
      `CHK(regs, 40'h0)
      for (int a = 8'h0c; a <= 8'h10; a++) rd_chk(a[7:0], 8'h00);
   endtask : check_reset
   task automatic write_all;
      logic [7:0] v[5] = '{8'h31, 8'hc8, 8'h32, 8'h7f, 8'h96};
      for (int i = 0; i < 5; i++) wr(8'h0c + i[7:0], v[i]);
      `CHK(regs, 40'h31c8327f96)
      for (int i = 0; i < 5; i++) rd_chk(8'h0c + i[7:0], v[i]);
   endtask : write_all
   task automatic unmapped;
      wr(8'h0b, 8'hff);
      wr(8'h11, 8'h55);
      `CHK(regs, 40'h31c8327f96)
      `CHK(cfg_error, 1'b0)
      rd_chk(8'h0b, 8'h00);
      rd_chk(8'hff, 8'h00);
   endtask : unmapped
   task automatic modes;
      power_source_select = 1'b1;
      compound_device = 1'b1;
      tick(3);
      `CHK(descriptor, 64'h3132006200640_12c)
      `CHK(peripheral_power_relevant, 1'b1)
      power_source_select = 1'b0;
      compound_device = 1'b0;
      tick(3);
      `CHK(descriptor, 64'hc87f019000fe012c)
      `CHK(peripheral_power_relevant, 1'b0)
      `CHK(self_power_limit_exceeded, 1'b0)
      wr(8'h0c, 8'h33);
      `CHK(self_power_limit_exceeded, 1'b1)
   endtask : modes
   task automatic defaults;
      // The load stands over two edges; the write taken at the second one must lose.
      load_defaults = 1'b1;
      wr(8'h0e, 8'h10);
      load_defaults = 1'b0;
      `CHK(regs, 40'h33c8323296)
   endtask : defaults
   task automatic reset_mid;
      rd_chk(8'h0d, 8'hc8);
      arst_n = 1'b0;
      tick(2);
      `CHK(regs, 40'h0)
      `CHK(descriptor, 64'h0)
      `CHK(cfg_rdata, 8'h00)
      arst_n = 1'b1;
      rd_chk(8'h0e, 8'h00);
   endtask : reset_mid
   task automatic results;
      $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      results();
   end
   initial begin
      arst_n = 1'b0;
      load_defaults = 1'b0;
      power_source_select = 1'b0;
      compound_device = 1'b0;
      tick(16);
      arst_n = 1'b1;
      check_reset();
      write_all();
      unmapped();
      modes();
      defaults();
      reset_mid();
      results();
   end
endmodule : hub_power_config_registers_tb_top
